// ===== gpio_irq_pkg.sv
// Purpose: constants and carriers for the port input-mode and pin-interrupt block
// Assumes: register indices map to byte address index*4 on the bus
// Notes:   all register fields reset to zero
`default_nettype none

package gpio_irq_pkg;

  // ===========================================================
  // bus geometry and register indices
  localparam int ADDR_W = 12;
  localparam int IDX_W  = ADDR_W - 2;

  localparam logic [IDX_W-1:0] IDX_P0_FLAGS = 10'h089;
  localparam logic [IDX_W-1:0] IDX_P1_FLAGS = 10'h08A;
  localparam logic [IDX_W-1:0] IDX_P2_FLAGS = 10'h08B;
  localparam logic [IDX_W-1:0] IDX_PORT_IRQ_CONTROL    = 10'h08C;
  localparam logic [IDX_W-1:0] IDX_P1_MASK  = 10'h08D;
  localparam logic [IDX_W-1:0] IDX_P0_MODE  = 10'h08F;
  localparam logic [IDX_W-1:0] IDX_P2_CFG   = 10'h0F7;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h0E0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0E1;

  // ===========================================================
  // widths, field positions, masks, reset values
  localparam int P0_W = 8;
  localparam int P1_W = 8;
  localparam int P2_W = 5;
  localparam int PINS = P0_W + P1_W + P2_W;
  localparam int EV_W = 3;
  localparam int P0_HIGH_LSB = 4;
  localparam int POS_DRIVE   = 6;
  localparam int POS_P2_PULL = 7;
  localparam logic [7:0] PORT_IRQ_CONTROL_WMASK = 8'h7F;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam int SYNC_STAGES = 3;

  // ===========================================================
  // register carriers
  typedef struct packed {
    logic unused;
    logic drive_strength_sel;
    logic p2_irq_on;
    logic p0_high_irq_on;
    logic p0_low_irq_on;
    logic p2_edge_sel;
    logic p1_edge_sel;
    logic p0_edge_sel;
  } port_irq_control_t;

  typedef struct packed {
    logic       p2_pull_dir;
    logic       p1_pull_dir;
    logic       p0_pull_dir;
    logic [4:0] p2_tristate_sel;
  } p2cfg_t;

endpackage : gpio_irq_pkg

`default_nettype wire

// ===== gpio_irq.sv
// Purpose: port input-mode, pull and pin-interrupt logic behind an APB slave
// Assumes: pins are asynchronous; one clock CLK; APB4 master with PSTRB
// Notes:   zero-wait slave, read data captured in the setup cycle
//
// Overview of operation
// - input-config bit 7 picks pull-down or pull-up for port 2 pulled pins
// - input-config bit 6 picks pull-down or pull-up for port 1 pulled pins
// - input-config bit 5 picks pull-down or pull-up for port 0 pulled pins
// - input-config bits 4:0 pick pulled or tristate per port 2 pin; reset zero
// - port 0 flags set on pin request; writing zero clears a flag
// - port 1 flags set on pin request; writing zero clears a flag
// - port 2 flags 4:0 set on request, cleared by zero; 7:5 read zero
// - control bit 6 selects minimum or maximum output drive
// - control bit 5 enables port 2 interrupt requests
// - control bit 4 enables port 0 pins 7 to 4 requests
// - control bit 3 enables port 0 pins 3 to 0 requests
// - control bit 2 picks rising or falling edge for port 2
// - control bit 1 picks rising or falling edge for port 1
// - control bit 0 picks rising or falling edge for port 0
// - each port 1 pin has its own interrupt enable bit
// - each port 0 pin has a pulled or tristate input-mode bit
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module gpio_irq (
  input  wire logic                              CLK,
  input  wire logic                              RST,
  input  wire logic                              CE,
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [gpio_irq_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [31:0]                       PWDATA,
  input  wire logic [3:0]                        PSTRB,
  output logic                                   PREADY,
  output logic [31:0]                            PRDATA,
  output logic                                   PSLVERR,
  input  wire logic [gpio_irq_pkg::P0_W-1:0]     P0_IN,
  input  wire logic [gpio_irq_pkg::P1_W-1:0]     P1_IN,
  input  wire logic [gpio_irq_pkg::P2_W-1:0]     P2_IN,
  output logic [gpio_irq_pkg::P0_W-1:0]          P0_TRISTATE,
  output logic [gpio_irq_pkg::P2_W-1:0]          P2_TRISTATE,
  output logic                                   P0_PULL_DOWN,
  output logic                                   P1_PULL_DOWN,
  output logic                                   P2_PULL_DOWN,
  output logic                                   DRIVE_MAX,
  output logic                                   P0_IRQ,
  output logic                                   P1_IRQ,
  output logic                                   P2_IRQ,
  output logic                                   IRQ
);

  // ===========================================================
  // state
  logic [gpio_irq_pkg::P0_W-1:0]  p0_pending;
  logic [gpio_irq_pkg::P1_W-1:0]  p1_pending;
  logic [gpio_irq_pkg::P2_W-1:0]  p2_pending;
  gpio_irq_pkg::port_irq_control_t           port_irq_control;
  gpio_irq_pkg::p2cfg_t           p2cfg;
  logic [gpio_irq_pkg::P1_W-1:0]  p1_pin_irq_mask;
  logic [gpio_irq_pkg::P0_W-1:0]  p0_tristate_sel;
  logic [gpio_irq_pkg::EV_W-1:0]  irq_stat;
  logic [gpio_irq_pkg::EV_W-1:0]  irq_mask;
  logic [gpio_irq_pkg::EV_W-1:0]  stat_snap;
  logic [gpio_irq_pkg::PINS-1:0]  sync1;
  logic [gpio_irq_pkg::PINS-1:0]  sync2;
  logic [gpio_irq_pkg::PINS-1:0]  sync3;
  logic [gpio_irq_pkg::PINS-1:0]  stable;
  logic [gpio_irq_pkg::PINS-1:0]  pins_in;
  logic [gpio_irq_pkg::SYNC_STAGES-1:0] prime_sr;
  logic                           primed;
  logic [gpio_irq_pkg::PINS-1:0]  pin_chg;
  logic [gpio_irq_pkg::PINS-1:0]  pin_ev;
  logic [gpio_irq_pkg::PINS-1:0]  edge_fall;
  logic [gpio_irq_pkg::EV_W-1:0]  next_req;
  logic [7:0]                     wbyte;
  logic [7:0]                     next_rd;
  logic                           access;
  logic                           setup;
  logic                           mapped;
  logic                           wr_en;
  logic                           rd_done;

  // ===========================================================
  // address decode
  function automatic logic hit(
    input logic [gpio_irq_pkg::ADDR_W-1:0] a,
    input logic [gpio_irq_pkg::IDX_W-1:0]  idx
  );
    return (a[1:0] == 2'h0) && (a[gpio_irq_pkg::ADDR_W-1:2] == idx);
  endfunction : hit

  assign setup  = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && CE;
  assign mapped = hit(PADDR, gpio_irq_pkg::IDX_P0_FLAGS)
               || hit(PADDR, gpio_irq_pkg::IDX_P1_FLAGS)
               || hit(PADDR, gpio_irq_pkg::IDX_P2_FLAGS)
               || hit(PADDR, gpio_irq_pkg::IDX_PORT_IRQ_CONTROL)
               || hit(PADDR, gpio_irq_pkg::IDX_P1_MASK)
               || hit(PADDR, gpio_irq_pkg::IDX_P0_MODE)
               || hit(PADDR, gpio_irq_pkg::IDX_P2_CFG)
               || hit(PADDR, gpio_irq_pkg::IDX_IRQ_STAT)
               || hit(PADDR, gpio_irq_pkg::IDX_IRQ_MASK);

  // freezing the clock enable also stalls the bus
  assign PREADY  = CE;
  assign PSLVERR = access && !mapped;
  assign wr_en   = access && PWRITE && mapped && PSTRB[0];
  assign rd_done = access && !PWRITE;
  assign wbyte   = PWDATA[7:0];

  // ===========================================================
  // read path
  always_comb
  begin
    next_rd = gpio_irq_pkg::RST_BYTE;
    case (PADDR[gpio_irq_pkg::ADDR_W-1:2])
      gpio_irq_pkg::IDX_P0_FLAGS: next_rd = p0_pending;
      gpio_irq_pkg::IDX_P1_FLAGS: next_rd = p1_pending;
      gpio_irq_pkg::IDX_P2_FLAGS: next_rd = {3'h0, p2_pending};
      gpio_irq_pkg::IDX_PORT_IRQ_CONTROL:    next_rd = port_irq_control;
      gpio_irq_pkg::IDX_P1_MASK:  next_rd = p1_pin_irq_mask;
      gpio_irq_pkg::IDX_P0_MODE:  next_rd = p0_tristate_sel;
      gpio_irq_pkg::IDX_P2_CFG:   next_rd = p2cfg;
      gpio_irq_pkg::IDX_IRQ_STAT: next_rd = {5'h00, irq_stat};
      gpio_irq_pkg::IDX_IRQ_MASK: next_rd = {5'h00, irq_mask};
      default:                    next_rd = gpio_irq_pkg::RST_BYTE;
    endcase
    if (PADDR[1:0] != 2'h0)
    begin
      next_rd = gpio_irq_pkg::RST_BYTE;
    end
  end

  // captured in setup so the data output comes from a flop
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PRDATA    <= 32'h0000_0000;
      stat_snap <= 3'h0;
    end
    else if (CE && setup)
    begin
      PRDATA    <= {24'h00_0000, next_rd};
      stat_snap <= hit(PADDR, gpio_irq_pkg::IDX_IRQ_STAT) ? irq_stat : 3'h0;
    end
  end

  // ===========================================================
  // pin synchroniser and edge detection
  // stable follows stage 2 until the pipe is full, so a pin high at reset gives no edge
  assign pins_in = {P2_IN, P1_IN, P0_IN};

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      prime_sr <= '0;
    end
    else if (CE)
    begin
      prime_sr <= {prime_sr[gpio_irq_pkg::SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign primed = prime_sr[gpio_irq_pkg::SYNC_STAGES-1];

  genvar gi;
  generate
    for (gi = 0; gi < gpio_irq_pkg::PINS; gi++)
    begin : g_pin
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          sync1[gi]  <= 1'b0;
          sync2[gi]  <= 1'b0;
          sync3[gi]  <= 1'b0;
          stable[gi] <= 1'b0;
        end
        else if (CE)
        begin
          sync1[gi] <= pins_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (!primed)
          begin
            stable[gi] <= sync2[gi];
          end
          else if (sync2[gi] == sync3[gi])
          begin
            stable[gi] <= sync3[gi];
          end
        end
      end

      assign edge_fall[gi] = (gi < gpio_irq_pkg::P0_W) ? port_irq_control.p0_edge_sel
                           : (gi < gpio_irq_pkg::P0_W + gpio_irq_pkg::P1_W)
                             ? port_irq_control.p1_edge_sel : port_irq_control.p2_edge_sel;
      assign pin_chg[gi] = CE && primed && (sync2[gi] == sync3[gi])
                           && (sync3[gi] != stable[gi]);
      assign pin_ev[gi]  = pin_chg[gi] && (sync3[gi] != edge_fall[gi]);
    end
  endgenerate

  // ===========================================================
  // interrupt status flags; a same-cycle event beats a clearing write
  // port 0 flags
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      p0_pending <= gpio_irq_pkg::RST_BYTE;
    end
    else if (CE)
    begin
      if (wr_en && hit(PADDR, gpio_irq_pkg::IDX_P0_FLAGS))
      begin
        p0_pending <= (p0_pending & wbyte) | pin_ev[7:0];
      end
      else
      begin
        p0_pending <= p0_pending | pin_ev[7:0];
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      p1_pending <= gpio_irq_pkg::RST_BYTE;
    end
    else if (CE)
    begin
      if (wr_en && hit(PADDR, gpio_irq_pkg::IDX_P1_FLAGS))
      begin
        p1_pending <= (p1_pending & wbyte) | pin_ev[15:8];
      end
      else
      begin
        p1_pending <= p1_pending | pin_ev[15:8];
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      p2_pending <= 5'h00;
    end
    else if (CE)
    begin
      if (wr_en && hit(PADDR, gpio_irq_pkg::IDX_P2_FLAGS))
      begin
        p2_pending <= (p2_pending & wbyte[4:0]) | pin_ev[20:16];
      end
      else
      begin
        p2_pending <= p2_pending | pin_ev[20:16];
      end
    end
  end

  // ===========================================================
  // configuration registers
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      port_irq_control           <= gpio_irq_pkg::RST_BYTE;
      p2cfg           <= gpio_irq_pkg::RST_BYTE;
      p1_pin_irq_mask <= gpio_irq_pkg::RST_BYTE;
      p0_tristate_sel <= gpio_irq_pkg::RST_BYTE;
      irq_mask        <= 3'h0;
    end
    else if (wr_en)
    begin
      if (hit(PADDR, gpio_irq_pkg::IDX_PORT_IRQ_CONTROL))
      begin
        port_irq_control <= wbyte & gpio_irq_pkg::PORT_IRQ_CONTROL_WMASK;
      end
      if (hit(PADDR, gpio_irq_pkg::IDX_P2_CFG))
      begin
        p2cfg <= wbyte;
      end
      if (hit(PADDR, gpio_irq_pkg::IDX_P1_MASK))
      begin
        p1_pin_irq_mask <= wbyte;
      end
      if (hit(PADDR, gpio_irq_pkg::IDX_P0_MODE))
      begin
        p0_tristate_sel <= wbyte;
      end
      if (hit(PADDR, gpio_irq_pkg::IDX_IRQ_MASK))
      begin
        irq_mask <= wbyte[2:0];
      end
    end
  end

  assign P0_TRISTATE  = p0_tristate_sel;
  assign P2_TRISTATE  = p2cfg.p2_tristate_sel;
  assign P0_PULL_DOWN = p2cfg.p0_pull_dir;
  assign P1_PULL_DOWN = p2cfg.p1_pull_dir;
  assign P2_PULL_DOWN = p2cfg.p2_pull_dir;
  assign DRIVE_MAX    = port_irq_control.drive_strength_sel;

  // ===========================================================
  // port requests and summary interrupt
  // request per port
  always_comb
  begin
    next_req[0] = (port_irq_control.p0_high_irq_on && (p0_pending[7:4] != 4'h0))
               || (port_irq_control.p0_low_irq_on && (p0_pending[3:0] != 4'h0));
    next_req[1] = (p1_pending & p1_pin_irq_mask) != 8'h00;
    next_req[2] = port_irq_control.p2_irq_on && (p2_pending != 5'h00);
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      P0_IRQ <= 1'b0;
      P1_IRQ <= 1'b0;
      P2_IRQ <= 1'b0;
    end
    else if (CE)
    begin
      P0_IRQ <= next_req[0];
      P1_IRQ <= next_req[1];
      P2_IRQ <= next_req[2];
    end
  end

  // only bits seen by the read are cleared, so a later request survives
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      irq_stat <= 3'h0;
    end
    else if (CE)
    begin
      if (rd_done && hit(PADDR, gpio_irq_pkg::IDX_IRQ_STAT))
      begin
        irq_stat <= (irq_stat & ~stat_snap) | next_req;
      end
      else
      begin
        irq_stat <= irq_stat | next_req;
      end
    end
  end

  assign IRQ = (irq_stat & irq_mask) != 3'h0;

  // ===========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_p0_flag_set: assert property (pin_ev[0] |=> p0_pending[0])
    else $error("port 0 flag missed its edge");
  a_p1_flag_set: assert property (pin_ev[8] |=> p1_pending[0])
    else $error("port 1 flag missed its edge");
  a_p0_flag_clear: assert property (
    wr_en && hit(PADDR, gpio_irq_pkg::IDX_P0_FLAGS) && !PWDATA[0] && !pin_ev[0]
    |=> !p0_pending[0])
    else $error("zero write did not clear port 0 flag");
  a_p2_read_high: assert property (
    CE && setup && hit(PADDR, gpio_irq_pkg::IDX_P2_FLAGS) |=> PRDATA[7:5] == 3'h0)
    else $error("unused port 2 flag bits read nonzero");
  a_rise_edge_p0: assert property (
    pin_chg[0] && sync3[0] && !port_irq_control.p0_edge_sel |-> pin_ev[0])
    else $error("rising edge not taken on port 0");
  a_fall_edge_p2: assert property (
    pin_chg[16] && sync3[16] && port_irq_control.p2_edge_sel |-> !pin_ev[16])
    else $error("rising edge taken while falling selected");
  a_p0_high_gate: assert property (
    CE && port_irq_control.p0_high_irq_on && p0_pending[gpio_irq_pkg::P0_HIGH_LSB] |=> P0_IRQ)
    else $error("port 0 high request not raised");
  a_p2_irq_off: assert property (
    CE && !port_irq_control.p2_irq_on |=> !P2_IRQ)
    else $error("port 2 request while disabled");
  a_p1_pin_mask: assert property (
    CE && ((p1_pending & p1_pin_irq_mask) == 8'h00) |=> !P1_IRQ)
    else $error("port 1 request from masked pins");
  a_pull_dir_p2: assert property (
    wr_en && hit(PADDR, gpio_irq_pkg::IDX_P2_CFG) && PWDATA[gpio_irq_pkg::POS_P2_PULL]
    |=> P2_PULL_DOWN)
    else $error("port 2 pull direction not applied");
  a_drive_sel: assert property (
    wr_en && hit(PADDR, gpio_irq_pkg::IDX_PORT_IRQ_CONTROL) && PWDATA[gpio_irq_pkg::POS_DRIVE]
    |=> DRIVE_MAX)
    else $error("drive strength not applied");

  c_p1_event: cover property (pin_ev[8] ##1 P1_IRQ);
  c_irq_up: cover property (!IRQ ##1 IRQ);
  c_stat_clear: cover property (rd_done && hit(PADDR, gpio_irq_pkg::IDX_IRQ_STAT));
  c_slverr: cover property (PSLVERR);

endmodule : gpio_irq

`default_nettype wire

// ===== gpio_irq_bind_note_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for the port input-mode and pin-interrupt block
// Assumes: zero-wait APB slave, byte address = index*4, pins settle within 8 edges
// Notes:   reads queue their expected word; a monitor compares at the access edge
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================
  // signals and instance
  logic                              CLK = 1'b0;
  logic                              RST = 1'b1;
  logic                              CE = 1'b1;
  logic                              PSEL = 1'b0;
  logic                              PENABLE = 1'b0;
  logic                              PWRITE = 1'b0;
  logic [gpio_irq_pkg::ADDR_W-1:0]   PADDR = '0;
  logic [31:0]                       PWDATA = '0;
  logic [3:0]                        PSTRB = '0;
  logic [7:0]                        P0_IN = '0;
  logic [7:0]                        P1_IN = '0;
  logic [4:0]                        P2_IN = '0;
  wire logic                         PREADY, PSLVERR, DRIVE_MAX, IRQ;
  wire logic [31:0]                  PRDATA;
  wire logic [7:0]                   P0_TRISTATE;
  wire logic [4:0]                   P2_TRISTATE;
  wire logic                         P0_PULL_DOWN, P1_PULL_DOWN, P2_PULL_DOWN;
  wire logic                         P0_IRQ, P1_IRQ, P2_IRQ;
  int                                n_mismatch = 0;
  int                                compares = 0;
  integer                            seed = 32'h6FAC;
  logic [32:0]                       rd_q[$];

  gpio_irq u_dut (.CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
    .PRDATA(PRDATA), .PSLVERR(PSLVERR), .P0_IN(P0_IN), .P1_IN(P1_IN), .P2_IN(P2_IN),
    .P0_TRISTATE(P0_TRISTATE), .P2_TRISTATE(P2_TRISTATE), .P0_PULL_DOWN(P0_PULL_DOWN),
    .P1_PULL_DOWN(P1_PULL_DOWN), .P2_PULL_DOWN(P2_PULL_DOWN), .DRIVE_MAX(DRIVE_MAX),
    .P0_IRQ(P0_IRQ), .P1_IRQ(P1_IRQ), .P2_IRQ(P2_IRQ), .IRQ(IRQ));

  always #20 CLK = ~CLK;

  // ==========================================================
  // compare, verdict and bus tasks
  task automatic chk_rd(input logic [32:0] exp, input logic [32:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED read exp %h got %h", exp, got);
    end
  endtask : chk_rd

  task automatic chk_pin(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk_pin

  task automatic end_of_test;
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  function automatic logic [11:0] ba(input logic [gpio_irq_pkg::IDX_W-1:0] i);
    return {i, 2'b00};
  endfunction : ba

  // one transfer; an idle edge follows so strobes never toggle twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= {24'h000000, d};
    PSTRB   <= 4'hF;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err = 1'b0);
    rd_q.push_back({err, 24'h000000, e});
    apb(1'b0, a, 8'h00);
  endtask : rd

  // ==========================================================
  // read monitor and watchdog
  always @(posedge CLK)
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
    begin
      if (rd_q.size() == 0)
        chk_rd(33'h0, 33'h1FFFFFFFF);
      else
        chk_rd(rd_q.pop_front(), {PSLVERR, PRDATA});
    end

  initial
  begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    logic [7:0] p0, p1, w, m, f0, idle;
    logic [4:0] p2;
    logic [2:0] k;
    logic [9:0] tab [9];
    tab = '{10'h089, 10'h08A, 10'h08B, 10'h08C, 10'h08D, 10'h08F, 10'h0F7, 10'h0E0, 10'h0E1};
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk_pin("cfg", 8'h00, {P2_PULL_DOWN, P1_PULL_DOWN, P0_PULL_DOWN, P2_TRISTATE});
    for (int i = 0; i < 9; i++)
      rd(ba(tab[i]), 8'h00);
    // control bit 7 reads zero
    wr(ba(gpio_irq_pkg::IDX_PORT_IRQ_CONTROL), 8'hFF);
    rd(ba(gpio_irq_pkg::IDX_PORT_IRQ_CONTROL), 8'h7F);
    chk_pin("drive", 8'h01, {7'h00, DRIVE_MAX});
    wr(ba(gpio_irq_pkg::IDX_PORT_IRQ_CONTROL), 8'h00);
    chk_pin("drive", 8'h00, {7'h00, DRIVE_MAX});
    for (int i = 0; i < 4; i++)
    begin
      w = $random(seed);
      m = $random(seed);
      wr(ba(gpio_irq_pkg::IDX_P2_CFG), w);
      wr(ba(gpio_irq_pkg::IDX_P0_MODE), m);
      wr(ba(gpio_irq_pkg::IDX_IRQ_MASK), m);
      rd(ba(gpio_irq_pkg::IDX_P2_CFG), w);
      rd(ba(gpio_irq_pkg::IDX_IRQ_MASK), m & 8'h07);
      chk_pin("cfg", w,
        {P2_PULL_DOWN, P1_PULL_DOWN, P0_PULL_DOWN, P2_TRISTATE});
      chk_pin("p0mode", m, P0_TRISTATE);
    end
    // unmapped and unaligned places answer with an error
    rd(12'h240, 8'h00, 1'b1);
    rd(12'h225, 8'h00, 1'b1);
    // edge select: rising then falling on all ports
    for (int e = 0; e < 2; e++)
    begin
      idle = e ? 8'hFF : 8'h00;
      wr(ba(gpio_irq_pkg::IDX_PORT_IRQ_CONTROL), e ? 8'h07 : 8'h00);
      P0_IN <= idle;
      P1_IN <= idle;
      P2_IN <= idle[4:0];
      repeat (8) @(posedge CLK);
      for (int i = 0; i < 3; i++)
        wr(ba(tab[i]), 8'h00);
      p0 = $random(seed) | 8'h01;
      p1 = $random(seed) | 8'h01;
      p2 = $random(seed) | 5'h01;
      P0_IN <= idle ^ p0;
      P1_IN <= idle ^ p1;
      P2_IN <= idle[4:0] ^ p2;
      repeat (8) @(posedge CLK);
      rd(ba(gpio_irq_pkg::IDX_P0_FLAGS), p0);
      rd(ba(gpio_irq_pkg::IDX_P1_FLAGS), p1);
      rd(ba(gpio_irq_pkg::IDX_P2_FLAGS), {3'b000, p2});
      P0_IN <= idle;
      P1_IN <= idle;
      P2_IN <= idle[4:0];
      repeat (8) @(posedge CLK);
      w = $random(seed) | 8'h01;
      wr(ba(gpio_irq_pkg::IDX_P0_FLAGS), w);
      wr(ba(gpio_irq_pkg::IDX_P2_FLAGS), 8'hFF);
      rd(ba(gpio_irq_pkg::IDX_P0_FLAGS), p0 & w);
      rd(ba(gpio_irq_pkg::IDX_P1_FLAGS), p1);
      rd(ba(gpio_irq_pkg::IDX_P2_FLAGS), {3'b000, p2});
    end
    f0 = p0 & w;
    // per-port request gating by enables
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      m = $random(seed);
      wr(ba(gpio_irq_pkg::IDX_P1_MASK), m);
      wr(ba(gpio_irq_pkg::IDX_PORT_IRQ_CONTROL), {2'b00, k, 3'b111});
      repeat (2) @(posedge CLK);
      chk_pin("req", {5'h00, k[2] & |p2, |(p1 & m),
        (k[1] & |f0[7:4]) | (k[0] & |f0[3:0])},
        {5'h00, P2_IRQ, P1_IRQ, P0_IRQ});
    end
    // interrupt mask, sticky status and read clear
    wr(ba(gpio_irq_pkg::IDX_P1_MASK), 8'hFF);
    wr(ba(gpio_irq_pkg::IDX_IRQ_MASK), 8'h00);
    repeat (2) @(posedge CLK);
    chk_pin("irq", 8'h00, {7'h00, IRQ});
    wr(ba(gpio_irq_pkg::IDX_IRQ_MASK), 8'h07);
    repeat (2) @(posedge CLK);
    chk_pin("irq", 8'h01, {7'h00, IRQ});
    for (int i = 0; i < 3; i++)
      wr(ba(tab[i]), 8'h00);
    repeat (3) @(posedge CLK);
    chk_pin("req", 8'h00, {5'h00, P2_IRQ, P1_IRQ, P0_IRQ});
    rd(ba(gpio_irq_pkg::IDX_IRQ_STAT), 8'h07);
    rd(ba(gpio_irq_pkg::IDX_IRQ_STAT), 8'h00);
    chk_pin("irq", 8'h00, {7'h00, IRQ});
    // clock enable low stalls the bus
    CE <= 1'b0;
    repeat (2) @(posedge CLK);
    chk_pin("ready", 8'h00, {7'h00, PREADY});
    CE <= 1'b1;
    // reset in mid-run returns the input-config fields to zero
    wr(ba(gpio_irq_pkg::IDX_P2_CFG), 8'hFF);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk_pin("cfg", 8'h00, {P2_PULL_DOWN, P1_PULL_DOWN, P0_PULL_DOWN, P2_TRISTATE});
    rd(ba(gpio_irq_pkg::IDX_P2_CFG), 8'h00);
    repeat (4) @(posedge CLK);
    // pins held high through reset must not look like a rising edge
    for (int i = 0; i < 3; i++)
      rd(ba(tab[i]), 8'h00);
    if (rd_q.size() != 0)
      n_mismatch++;
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
